// ---- pkg/bdrv_params.svh ----
`ifndef BDRV_PARAMS_SVH
`define BDRV_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define BDRV_CLK_PERIOD_NS 10
`define BDRV_MIN_BIT_NS 60
// Least time, rounded up to whole cycles
`define BDRV_MIN_BIT_CYC ((`BDRV_MIN_BIT_NS + `BDRV_CLK_PERIOD_NS - 1) / `BDRV_CLK_PERIOD_NS)

// ****************************************
// Receive buffer
// ****************************************
`define BDRV_RX_FIFO_DEPTH 16
`define BDRV_SYM_W 2

// ****************************************
// Levels of floating inputs
// ****************************************
`define BDRV_DEF_TX_SERIAL_IN 1'b0
`define BDRV_DEF_TX_ENABLE_N 1'b1
`define BDRV_DEF_MODE_SELECT_B_N 1'b0
`define BDRV_DEF_MODE_SELECT_A 1'b0
`define BDRV_DEF_GUARDIAN_ENABLE 1'b0

// ****************************************
// Reset values of outputs
// ****************************************
`define BDRV_RST_RX_SERIAL_OUT 1'b0
`define BDRV_RST_RX_ACTIVITY_N 1'b0

`endif

// ---- pkg/bdrv_pkg.sv ----
`default_nettype none

package bdrv_pkg;

    // Gray codes along standby, normal, listen, goto, sleep, unpowered
    typedef enum logic [2:0] {
        DRV_STANDBY = 3'h0,
        DRV_NORMAL = 3'h1,
        DRV_LISTEN_ONLY = 3'h3,
        DRV_GOTO_SLEEP = 3'h2,
        DRV_SLEEP = 3'h6,
        DRV_UNPOWERED = 3'h7
    } bdrv_mode_type;

    typedef enum logic [1:0] {
        SYM_IDLE = 2'h0,
        SYM_DATA_0 = 2'h1,
        SYM_DATA_1 = 2'h2
    } bdrv_sym_type;

    typedef enum logic [1:0] {
        BIAS_OPEN = 2'h0,
        BIAS_GND = 2'h1,
        BIAS_LEVEL = 2'h2
    } bdrv_bias_type;

    typedef struct packed {
        bdrv_mode_type mode;
        logic tx_on;
        logic tx_drive;
        logic tx_level;
        bdrv_bias_type bias;
        logic pull_en;
        bdrv_sym_type rx_sym;
        logic rxd;
        logic rx_activity_n_n;
    } bdrv_main_state_type;

endpackage

`default_nettype wire

// ---- verilog/bdrv_fifo.sv ----
`default_nettype none

module bdrv_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } bdrv_fifo_state_type;

    bdrv_fifo_state_type s_q, s_d;
    logic full, empty, push, pop;

    assign empty = (s_q.wr == s_q.rd);
    assign full = (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]) && (s_q.wr[AW] != s_q.rd[AW]);
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = s_q.mem[s_q.rd[AW-1:0]];

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr[AW-1:0]] = in_data_i;
            s_d.wr = s_q.wr + (AW + 1)'(1);
        end
        if (pop) begin
            s_d.rd = s_q.rd + (AW + 1)'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    chk_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        full && !pop |=> $stable(s_q.wr))
        else $error("fifo write pointer moved while full");

endmodule

`default_nettype wire

// ---- verilog/bdrv_rx_filter.sv ----
`default_nettype none

module bdrv_rx_filter #(
    parameter int SYM_W = 2,
    parameter int MIN_CYC = 6
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [SYM_W-1:0] sym_i,
    input wire logic ready_i,
    output logic [SYM_W-1:0] sym_o,
    output logic valid_o
);

    localparam int CW = $clog2(MIN_CYC + 1);
    localparam logic [CW-1:0] MIN_C = CW'(MIN_CYC);

    typedef struct packed {
        logic [SYM_W-1:0] cand;
        logic [CW-1:0] cnt;
        logic [SYM_W-1:0] out;
        logic valid;
    } bdrv_filt_state_type;

    bdrv_filt_state_type s_q, s_d;

    assign sym_o = s_q.out;
    assign valid_o = s_q.valid;

    // A full buffer freezes the filter so no symbol is dropped
    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b1;
        if (ready_i) begin
            if (sym_i != s_q.cand) begin
                s_d.cand = sym_i;
                s_d.cnt = CW'(1);
            end else if (s_q.cnt < MIN_C) begin
                s_d.cnt = s_q.cnt + CW'(1);
            end
            if (s_d.cnt == MIN_C) begin
                s_d.out = s_d.cand;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    chk_filter_min_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sym_o != $past(sym_o)) |-> ($past(s_q.cnt) == MIN_C - CW'(1)) && ($past(sym_i) == sym_o))
        else $error("symbol accepted before minimum bit time");

endmodule

`default_nettype wire

// ---- verilog/bdrv_digital_if.sv ----
// Behaviour
// - In normal mode a floating enable or guardian input keeps the transmitter off.
// - Floating serial input with active transmitter sends Data_0.
// - Both mode inputs unconnected give standby mode.
// - Floating inputs take fixed defaults: data low, enable high, modes low, guardian low.
// - Sleep, standby, listen ignore transmit inputs and switch their pulls off.
// - A missing supply or reference moves the device to a fail-safe mode.
// - Transmitter may only be active in normal mode.
// - Driver off for Idle; drives only Data_0 or Data_1.
// - Receiver accepts bits down to the minimum bit time.
// - Outside low power, receive output high for Data_1, low for Data_0; the code forces it low when unpowered.
// - Bias level in normal and listen, ground in standby/goto/sleep, open unpowered.
// - Missing reference forces receive output low and transmit inputs to defaults.
// - Transmitter on only in normal mode with enable low and guardian high.
// - Enable is honoured only while serial input is low; never start with Data_1.
// - Enabled transmitter maps high to Data_1 and low to Data_0.
// - Low power modes disable transmit inputs; receive output shows the wake flag.
// - Missing reference forces activity output low and guardian to default.
// - Outside low power, activity output high for Idle, low for data; the code forces it low when unpowered.
// - In sleep or standby both outputs low with wake flag set, else high.
// - Mode inputs decode to normal, listen, goto-sleep then sleep, standby.
// - In normal mode a low guardian input disables the transmitter.
`include "bdrv_params.svh"
`default_nettype none

module bdrv_digital_if #(
    parameter int MIN_BIT_CYC = `BDRV_MIN_BIT_CYC,
    parameter int RX_FIFO_DEPTH = `BDRV_RX_FIFO_DEPTH
) (
    input wire logic MCLK_I,
    input wire logic NRST_I,
    input wire logic SUPPLY_OK_I,
    input wire logic IO_REF_OK_I,
    input wire logic WAKE_FLAG_I,
    input wire logic TX_SERIAL_IN_I,
    input wire logic TX_SERIAL_IN_OPEN_I,
    input wire logic TX_ENABLE_N_I,
    input wire logic TX_ENABLE_N_OPEN_I,
    input wire logic GUARDIAN_ENABLE_I,
    input wire logic GUARDIAN_ENABLE_OPEN_I,
    input wire logic MODE_SELECT_A_I,
    input wire logic MODE_SELECT_A_OPEN_I,
    input wire logic MODE_SELECT_B_N_I,
    input wire logic MODE_SELECT_B_N_OPEN_I,
    input wire logic [1:0] BUS_RX_SYMBOL_I,
    input wire logic RX_HOLD_I,
    output logic RX_SERIAL_OUT_O,
    output logic RX_ACTIVITY_N_O,
    output logic BUS_TX_DRIVE_O,
    output logic BUS_TX_LEVEL_O,
    output logic [1:0] BUS_BIAS_O,
    output logic INPUT_PULL_EN_O,
    output logic [2:0] MODE_O
);

    // ****************************************
    // Reset release
    // ****************************************
    logic [2:0] rst_sync_q;
    logic rst_n;

    // Top bit arms the checks on the same edge at which the state first leaves reset
    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rst_sync_q <= 3'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[1:0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ****************************************
    // Receive path: filter and buffer
    // ****************************************
    logic [1:0] filt_sym;
    logic filt_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [1:0] fifo_out_data;
    logic fifo_out_ready;

    bdrv_rx_filter #(
        .SYM_W(`BDRV_SYM_W),
        .MIN_CYC(MIN_BIT_CYC)
    ) u_filter (
        .clk_i(MCLK_I),
        .rst_n_i(rst_n),
        .sym_i(BUS_RX_SYMBOL_I),
        .ready_i(fifo_in_ready),
        .sym_o(filt_sym),
        .valid_o(filt_valid)
    );

    // Hold from the far side backs up into the filter, which then freezes
    assign fifo_out_ready = !RX_HOLD_I;

    bdrv_fifo #(
        .WIDTH(`BDRV_SYM_W),
        .DEPTH(RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i(MCLK_I),
        .rst_n_i(rst_n),
        .in_valid_i(filt_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(filt_sym),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // ****************************************
    // Input resolution
    // ****************************************
    logic txd_r, tx_enable_n_n_r, bge_r, msel_a_r, msel_b_n_r;

    // Without the reference every input reads as its pulled level
    assign txd_r = (IO_REF_OK_I && !TX_SERIAL_IN_OPEN_I) ? TX_SERIAL_IN_I
        : `BDRV_DEF_TX_SERIAL_IN;
    assign tx_enable_n_n_r = (IO_REF_OK_I && !TX_ENABLE_N_OPEN_I) ? TX_ENABLE_N_I
        : `BDRV_DEF_TX_ENABLE_N;
    assign bge_r = (IO_REF_OK_I && !GUARDIAN_ENABLE_OPEN_I) ? GUARDIAN_ENABLE_I
        : `BDRV_DEF_GUARDIAN_ENABLE;
    assign msel_a_r = (IO_REF_OK_I && !MODE_SELECT_A_OPEN_I) ? MODE_SELECT_A_I
        : `BDRV_DEF_MODE_SELECT_A;
    assign msel_b_n_r = (IO_REF_OK_I && !MODE_SELECT_B_N_OPEN_I) ? MODE_SELECT_B_N_I
        : `BDRV_DEF_MODE_SELECT_B_N;

    // ****************************************
    // State
    // ****************************************
    bdrv_pkg::bdrv_main_state_type s_q, s_d;
    logic low_power, rx_live;

    assign low_power = (s_q.mode == bdrv_pkg::DRV_SLEEP) || (s_q.mode == bdrv_pkg::DRV_STANDBY)
        || (s_q.mode == bdrv_pkg::DRV_GOTO_SLEEP);
    assign rx_live = (s_q.mode == bdrv_pkg::DRV_NORMAL) || (s_q.mode == bdrv_pkg::DRV_LISTEN_ONLY);

    always_comb begin
        s_d = s_q;
        // Mode selection
        if (!SUPPLY_OK_I) begin
            s_d.mode = bdrv_pkg::DRV_UNPOWERED;
        end else if (!IO_REF_OK_I) begin
            s_d.mode = bdrv_pkg::DRV_SLEEP;
        end else begin
            case ({msel_b_n_r, msel_a_r})
                2'h3: begin
                    s_d.mode = bdrv_pkg::DRV_NORMAL;
                end
                2'h2: begin
                    s_d.mode = bdrv_pkg::DRV_LISTEN_ONLY;
                end
                2'h1: begin
                    // Goto-sleep is a one-cycle step on the way to sleep
                    if ((s_q.mode == bdrv_pkg::DRV_GOTO_SLEEP) || (s_q.mode == bdrv_pkg::DRV_SLEEP)) begin
                        s_d.mode = bdrv_pkg::DRV_SLEEP;
                    end else begin
                        s_d.mode = bdrv_pkg::DRV_GOTO_SLEEP;
                    end
                end
                default: begin
                    s_d.mode = bdrv_pkg::DRV_STANDBY;
                end
            endcase
        end

        // Transmitter: once on it follows the data; turning on needs data low
        s_d.tx_on = (s_q.mode == bdrv_pkg::DRV_NORMAL) && !tx_enable_n_n_r && bge_r
            && (s_q.tx_on || !txd_r);
        s_d.tx_drive = s_d.tx_on;
        s_d.tx_level = s_d.tx_on && txd_r;

        // Bus biasing
        case (s_q.mode)
            bdrv_pkg::DRV_NORMAL, bdrv_pkg::DRV_LISTEN_ONLY: begin
                s_d.bias = bdrv_pkg::BIAS_LEVEL;
            end
            bdrv_pkg::DRV_UNPOWERED: begin
                s_d.bias = bdrv_pkg::BIAS_OPEN;
            end
            default: begin
                s_d.bias = bdrv_pkg::BIAS_GND;
            end
        endcase

        // Pulls cost quiescent current where the inputs are ignored anyway
        s_d.pull_en = !((s_q.mode == bdrv_pkg::DRV_SLEEP) || (s_q.mode == bdrv_pkg::DRV_STANDBY)
            || (s_q.mode == bdrv_pkg::DRV_LISTEN_ONLY));

        // Receive outputs
        if (fifo_out_valid && fifo_out_ready) begin
            s_d.rx_sym = bdrv_pkg::bdrv_sym_type'(fifo_out_data);
        end
        if (!IO_REF_OK_I || (s_q.mode == bdrv_pkg::DRV_UNPOWERED)) begin
            s_d.rxd = 1'b0;
            s_d.rx_activity_n_n = 1'b0;
        end else if (rx_live) begin
            s_d.rxd = (s_q.rx_sym != bdrv_pkg::SYM_DATA_0);
            s_d.rx_activity_n_n = (s_q.rx_sym == bdrv_pkg::SYM_IDLE);
        end else begin
            s_d.rxd = !WAKE_FLAG_I;
            s_d.rx_activity_n_n = !WAKE_FLAG_I;
        end
    end

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            s_q.mode <= bdrv_pkg::DRV_STANDBY;
            s_q.tx_on <= 1'b0;
            s_q.tx_drive <= 1'b0;
            s_q.tx_level <= 1'b0;
            s_q.bias <= bdrv_pkg::BIAS_GND;
            s_q.pull_en <= 1'b0;
            s_q.rx_sym <= bdrv_pkg::SYM_IDLE;
            s_q.rxd <= `BDRV_RST_RX_SERIAL_OUT;
            s_q.rx_activity_n_n <= `BDRV_RST_RX_ACTIVITY_N;
        end else begin
            s_q <= s_d;
        end
    end

    assign RX_SERIAL_OUT_O = s_q.rxd;
    assign RX_ACTIVITY_N_O = s_q.rx_activity_n_n;
    assign BUS_TX_DRIVE_O = s_q.tx_drive;
    assign BUS_TX_LEVEL_O = s_q.tx_level;
    assign BUS_BIAS_O = s_q.bias;
    assign INPUT_PULL_EN_O = s_q.pull_en;
    assign MODE_O = s_q.mode;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge MCLK_I);
    endclocking
    // The edge that releases rst_n still runs the reset branch, so its attempts are skipped
    default disable iff (!rst_sync_q[2]);

    sequence tx_off_then_on;
        !BUS_TX_DRIVE_O ##1 BUS_TX_DRIVE_O;
    endsequence

    sequence goto_with_cmd;
        (MODE_O == bdrv_pkg::DRV_GOTO_SLEEP) && SUPPLY_OK_I && IO_REF_OK_I && !msel_b_n_r && msel_a_r;
    endsequence

    chk_tx_normal_only: assert property (
        BUS_TX_DRIVE_O |-> $past(s_q.mode) == bdrv_pkg::DRV_NORMAL)
        else $error("transmitter active outside normal mode");

    chk_tx_floating_off: assert property (
        (TX_ENABLE_N_OPEN_I || GUARDIAN_ENABLE_OPEN_I) |=> !BUS_TX_DRIVE_O)
        else $error("transmitter on with a floating enable input");

    chk_tx_guard_block: assert property (
        (IO_REF_OK_I && !GUARDIAN_ENABLE_OPEN_I && !GUARDIAN_ENABLE_I) |=> !BUS_TX_DRIVE_O)
        else $error("transmitter on with guardian low");

    chk_tx_activate: assert property (
        (s_q.mode == bdrv_pkg::DRV_NORMAL) && !tx_enable_n_n_r && bge_r && !txd_r |=> BUS_TX_DRIVE_O)
        else $error("transmitter did not turn on");

    chk_tx_start_low: assert property (
        tx_off_then_on |-> !BUS_TX_LEVEL_O)
        else $error("transmission started with Data_1");

    chk_tx_level_map: assert property (
        BUS_TX_DRIVE_O |-> BUS_TX_LEVEL_O == $past(txd_r))
        else $error("bus level does not follow serial input");

    chk_idle_undriven: assert property (
        !BUS_TX_DRIVE_O |-> !BUS_TX_LEVEL_O)
        else $error("level asserted while driver off");

    chk_bias_by_mode: assert property (
        ($past(s_q.mode) == bdrv_pkg::DRV_UNPOWERED) |-> BUS_BIAS_O == bdrv_pkg::BIAS_OPEN)
        else $error("bias not open when unpowered");

    chk_pull_off: assert property (
        (s_q.mode == bdrv_pkg::DRV_LISTEN_ONLY) || (s_q.mode == bdrv_pkg::DRV_SLEEP) |=> !INPUT_PULL_EN_O)
        else $error("pulls enabled in a quiet mode");

    chk_io_loss_low: assert property (
        !IO_REF_OK_I |=> !RX_SERIAL_OUT_O && !RX_ACTIVITY_N_O)
        else $error("receive outputs not low without reference");

    chk_wake_echo: assert property (
        IO_REF_OK_I && low_power |=> RX_SERIAL_OUT_O == !$past(WAKE_FLAG_I)
            && RX_ACTIVITY_N_O == RX_SERIAL_OUT_O)
        else $error("wake flag not shown in low power");

    chk_rx_map: assert property (
        IO_REF_OK_I && rx_live |=> RX_ACTIVITY_N_O == ($past(s_q.rx_sym) == bdrv_pkg::SYM_IDLE)
            && RX_SERIAL_OUT_O == ($past(s_q.rx_sym) != bdrv_pkg::SYM_DATA_0))
        else $error("receive symbol mapped wrongly");

    chk_default_standby: assert property (
        SUPPLY_OK_I && IO_REF_OK_I && MODE_SELECT_A_OPEN_I && MODE_SELECT_B_N_OPEN_I
            |=> MODE_O == bdrv_pkg::DRV_STANDBY)
        else $error("open mode inputs did not give standby");

    chk_goto_sleep: assert property (
        goto_with_cmd |=> MODE_O == bdrv_pkg::DRV_SLEEP)
        else $error("goto-sleep did not move on to sleep");

    chk_fail_safe: assert property (
        !SUPPLY_OK_I |=> MODE_O == bdrv_pkg::DRV_UNPOWERED ##1 BUS_BIAS_O == bdrv_pkg::BIAS_OPEN)
        else $error("no fail-safe mode on lost supply");

endmodule

`default_nettype wire

// ---- verification/bdrv_cc_model.sv ----
`default_nettype none

// ****************************************
// Controller side of the transmit pins
// ****************************************
module bdrv_cc_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic lead_low_i,
    input wire logic [3:0] bits_i,
    output logic txd_o,
    output logic tx_enable_n_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt = 0;
    // Released levels match the pin pulls, so idle is indistinguishable from open
    logic txd_q = 1'b0;
    logic tx_enable_n_n_q = 1'b1;

    assign txd_o = txd_q;
    assign tx_enable_n_n_o = tx_enable_n_n_q;

    always @(posedge clk_i) begin
        if (go_i && cnt == 0) begin
            tx_enable_n_n_q <= 1'b0;
            txd_q <= lead_low_i ? 1'b0 : bits_i[0];
            cnt <= 1;
        end else if (cnt == 5) begin
            tx_enable_n_n_q <= 1'b1;
            txd_q <= 1'b0;
            cnt <= 0;
        end else if (cnt > 0) begin
            txd_q <= bits_i[cnt-1];
            cnt <= cnt + 1;
        end
    end
endmodule

`default_nettype wire

// ---- verification/bdrv_digital_if_tb_top.sv ----
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch %s expected %h seen %h", nm, e, a); end end

module bdrv_digital_if_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    int fails = 0;
    int total_checks = 0;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_ok = 1'b1;
    logic io_ref_ok = 1'b1;
    logic wake = 1'b0;
    logic txd_open = 1'b0;
    logic tx_enable_n_open = 1'b0;
    logic guardian_enable = 1'b0;
    logic bge_open = 1'b0;
    logic msa = 1'b0;
    logic msa_open = 1'b0;
    logic msb_n = 1'b0;
    logic msb_open = 1'b0;
    logic [1:0] bus_sym = 2'h0;
    logic hold = 1'b0;
    logic go = 1'b0;
    logic lead = 1'b0;
    logic [3:0] bits = 4'h0;
    logic txd;
    logic tx_enable_n_n;
    logic rxd;
    logic rx_activity_n_n;
    logic drv;
    logic lvl;
    logic [1:0] bias;
    logic pull;
    logic [2:0] mode;

    always #5 mclk = ~mclk;

    bdrv_cc_model u_cc (.clk_i(mclk), .go_i(go), .lead_low_i(lead), .bits_i(bits), .txd_o(txd),
        .tx_enable_n_n_o(tx_enable_n_n));

    bdrv_digital_if #(.MIN_BIT_CYC(6), .RX_FIFO_DEPTH(16)) u_dut (.MCLK_I(mclk), .NRST_I(rst_n),
        .SUPPLY_OK_I(supply_ok), .IO_REF_OK_I(io_ref_ok), .WAKE_FLAG_I(wake), .TX_SERIAL_IN_I(txd),
        .TX_SERIAL_IN_OPEN_I(txd_open), .TX_ENABLE_N_I(tx_enable_n_n), .TX_ENABLE_N_OPEN_I(tx_enable_n_open),
        .GUARDIAN_ENABLE_I(guardian_enable), .GUARDIAN_ENABLE_OPEN_I(bge_open), .MODE_SELECT_A_I(msa),
        .MODE_SELECT_A_OPEN_I(msa_open), .MODE_SELECT_B_N_I(msb_n), .MODE_SELECT_B_N_OPEN_I(msb_open),
        .BUS_RX_SYMBOL_I(bus_sym), .RX_HOLD_I(hold), .RX_SERIAL_OUT_O(rxd), .RX_ACTIVITY_N_O(rx_activity_n_n),
        .BUS_TX_DRIVE_O(drv), .BUS_TX_LEVEL_O(lvl), .BUS_BIAS_O(bias), .INPUT_PULL_EN_O(pull),
        .MODE_O(mode));

    // ****************************************
    // Shared steps
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic set_mode(input logic bn, input logic a);
        msb_n = bn;
        msa = a;
        cyc(3);
    endtask

    // Output lag depends on buffer fill, so poll under a bound
    task automatic wait_rx(input string nm, input logic r, input logic e);
        int i;
        for (i = 0; i < 60 && !(rxd === r && rx_activity_n_n === e); i++) cyc(1);
        `CHK(nm, {r, e}, {rxd, rx_activity_n_n})
    endtask

    task automatic tx_run(input logic ll, input logic [3:0] b, input logic ok, input logic dz);
        logic [4:0] seq;
        logic on;
        logic eff;
        int j;
        seq = {b, ll ? 1'b0 : b[0]};
        on = 1'b0;
        lead = ll;
        bits = b;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        for (j = 0; j < 5; j++) begin
            cyc(1);
            eff = seq[j] & ~dz;
            on = on | (ok & ~eff);
            `CHK("tx drive", on, drv)
            `CHK("tx level", on & eff, lvl)
        end
        cyc(2);
        `CHK("tx release", 1'b0, drv)
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_modes();
        logic [2:0] em [4] = '{bdrv_pkg::DRV_NORMAL, bdrv_pkg::DRV_LISTEN_ONLY, bdrv_pkg::DRV_SLEEP,
            bdrv_pkg::DRV_STANDBY};
        logic [1:0] eb [4] = '{bdrv_pkg::BIAS_LEVEL, bdrv_pkg::BIAS_LEVEL, bdrv_pkg::BIAS_GND,
            bdrv_pkg::BIAS_GND};
        logic [3:0] ep = 4'b0001;
        int i;
        for (i = 0; i < 4; i++) begin
            {msb_n, msa} = 2'(3 - i);
            cyc(1);
            if (i == 2) `CHK("goto step", 3'(bdrv_pkg::DRV_GOTO_SLEEP), mode)
            cyc(2);
            `CHK("mode", em[i], mode)
            `CHK("bias", eb[i], bias)
            `CHK("pull", ep[i], pull)
        end
        msa_open = 1'b1;
        msb_open = 1'b1;
        set_mode(1'b1, 1'b1);
        `CHK("open mode", 3'(bdrv_pkg::DRV_STANDBY), mode)
        msa_open = 1'b0;
        msb_open = 1'b0;
    endtask

    task automatic t_tx();
        set_mode(1'b1, 1'b1);
        guardian_enable = 1'b1;
        tx_run(1'b1, 4'b1011, 1'b1, 1'b0);
        tx_run(1'b0, 4'b0011, 1'b1, 1'b0);
        txd_open = 1'b1;
        tx_run(1'b1, 4'b1111, 1'b1, 1'b1);
        txd_open = 1'b0;
        tx_enable_n_open = 1'b1;
        tx_run(1'b1, 4'b1010, 1'b0, 1'b0);
        tx_enable_n_open = 1'b0;
        bge_open = 1'b1;
        tx_run(1'b1, 4'b0110, 1'b0, 1'b0);
        bge_open = 1'b0;
        guardian_enable = 1'b0;
        tx_run(1'b1, 4'b0101, 1'b0, 1'b0);
        guardian_enable = 1'b1;
        set_mode(1'b1, 1'b0);
        tx_run(1'b1, 4'b1001, 1'b0, 1'b0);
    endtask

    task automatic t_rx();
        int i;
        int lows;
        set_mode(1'b1, 1'b1);
        bus_sym = 2'h1;
        wait_rx("rx data0", 1'b0, 1'b0);
        bus_sym = 2'h2;
        wait_rx("rx data1", 1'b1, 1'b0);
        bus_sym = 2'h0;
        wait_rx("rx idle", 1'b1, 1'b1);
        bus_sym = 2'h1;
        cyc(3);
        bus_sym = 2'h0;
        lows = 0;
        for (i = 0; i < 25; i++) begin
            cyc(1);
            lows += (rx_activity_n_n !== 1'b1);
        end
        `CHK("short bit", 0, lows)
        bus_sym = 2'h2;
        cyc(6);
        bus_sym = 2'h0;
        wait_rx("min bit", 1'b1, 1'b0);
        set_mode(1'b1, 1'b0);
        bus_sym = 2'h1;
        wait_rx("listen data0", 1'b0, 1'b0);
        bus_sym = 2'h0;
        wait_rx("listen idle", 1'b1, 1'b1);
    endtask

    // Stalled drain freezes the outputs; the stream must come out in order
    task automatic t_fifo();
        hold = 1'b1;
        bus_sym = 2'h2;
        cyc(8);
        bus_sym = 2'h1;
        cyc(30);
        `CHK("rx stalled", 2'b11, {rxd, rx_activity_n_n})
        hold = 1'b0;
        wait_rx("drain data1", 1'b1, 1'b0);
        wait_rx("drain data0", 1'b0, 1'b0);
        bus_sym = 2'h0;
        wait_rx("drain idle", 1'b1, 1'b1);
    endtask

    task automatic t_low();
        set_mode(1'b0, 1'b0);
        bus_sym = 2'h1;
        wake = 1'b1;
        wait_rx("wake set", 1'b0, 1'b0);
        wake = 1'b0;
        wait_rx("wake clear", 1'b1, 1'b1);
        bus_sym = 2'h0;
        set_mode(1'b1, 1'b1);
        io_ref_ok = 1'b0;
        cyc(3);
        `CHK("no ref mode", 3'(bdrv_pkg::DRV_SLEEP), mode)
        `CHK("no ref rx", 2'b00, {rxd, rx_activity_n_n})
        tx_run(1'b1, 4'b0101, 1'b0, 1'b0);
        io_ref_ok = 1'b1;
        supply_ok = 1'b0;
        cyc(3);
        `CHK("unpowered", 3'(bdrv_pkg::DRV_UNPOWERED), mode)
        `CHK("unpowered bias", 2'(bdrv_pkg::BIAS_OPEN), bias)
        supply_ok = 1'b1;
        cyc(3);
    endtask

    task automatic results();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #50000;
        fails++;
        results();
    end

    initial begin
        cyc(4);
        `CHK("reset outputs", {3'h0, 2'h1, 5'h0}, {mode, bias, drv, lvl, pull, rxd, rx_activity_n_n})
        cyc(1);
        rst_n = 1'b1;
        cyc(3);
        t_modes();
        t_tx();
        t_rx();
        t_fifo();
        t_low();
        results();
    end
endmodule

`default_nettype wire
